// file: cal_if.sv
// Interface joining the control register to the calibration sequencer.
`timescale 1ns/1ns
`default_nettype none
interface cal_if;
    logic enable;
    logic busy;
    logic done;

    // The control side drives enable and watches progress.
    modport ctrl (
        output enable,
        input busy,
        input done
    );

    // The sequencer side follows enable and reports progress.
    modport seq (
        input enable,
        output busy,
        output done
    );
endinterface
`default_nettype wire

// file: calibration_sequencer.sv
// Calibration sequencer that restarts whenever the synthesizer is enabled.
`timescale 1ns/1ns
`default_nettype none
module calibration_sequencer #(
    parameter int CalCycles = pll_ctrl_pkg::CAL_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    cal_if.seq cal
);
    localparam int CW = $clog2(CalCycles + 1);

    pll_ctrl_pkg::cal_state_e state;
    logic [CW-1:0] count;

    // A zero-length calibration has nothing to count.
    if (CalCycles < 1) begin
        $error("calibration length must be at least one cycle");
    end

    // Dropping enable returns to the held state from anywhere, so a
    // re-enable always starts the sequence from the beginning.
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= pll_ctrl_pkg::CAL_HELD;
            count <= '0;
        end else if (!cal.enable) begin
            state <= pll_ctrl_pkg::CAL_HELD;
            count <= '0;
        end else begin
            case (state)
                pll_ctrl_pkg::CAL_HELD: begin
                    state <= pll_ctrl_pkg::CAL_RUN;
                    count <= '0;
                end
                pll_ctrl_pkg::CAL_RUN: begin
                    if (count == CW'(CalCycles - 1)) begin
                        state <= pll_ctrl_pkg::CAL_DONE;
                    end
                    count <= count + 1'b1;
                end
                pll_ctrl_pkg::CAL_DONE: begin
                    state <= pll_ctrl_pkg::CAL_DONE;
                end
                default: begin
                    state <= pll_ctrl_pkg::CAL_HELD;
                    count <= '0;
                end
            endcase
        end
    end

    assign cal.busy = (state == pll_ctrl_pkg::CAL_RUN);
    assign cal.done = (state == pll_ctrl_pkg::CAL_DONE);
endmodule
`default_nettype wire

// file: pll_ctrl_pkg.sv
// Package with register map, field layout, reset values and timing.
`default_nettype none
package pll_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ZERO_ADDR = 8'h38;
    localparam logic [7:0] STATUS_ADDR = 8'h39;

    // ------------------------------------------------------------------
    // Field layout of pll_control_zero
    // ------------------------------------------------------------------
    localparam int POSTDIV_LSB = 2;
    localparam int POSTDIV_MSB = 4;
    localparam int SYNC_EN_BIT = 1;
    localparam int PDN_BIT = 0;

    // ------------------------------------------------------------------
    // Field layout of the status register
    // ------------------------------------------------------------------
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ENABLE_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] POSTDIV_RESET = 3'h7;
    localparam logic SYNC_EN_RESET = 1'b1;
    localparam logic PDN_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAL_TIME_NS = 10000;
    localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;

    // Calibration sequencer states.
    typedef enum logic [2:0] {
        CAL_HELD = 3'b001,
        CAL_RUN = 3'b010,
        CAL_DONE = 3'b100
    } cal_state_e;

endpackage
`default_nettype wire

// file: pll_post_divider_power_ctrl.sv
// Synthesizer post-divider, sync and powerdown control register block.
//
// Summary of operation
// - Post-divider code at bits 4:2, reset 7; codes 0,1 give 2, else code+1.
// - With sync enable set and powerdown clear, a sync event resynchronises synthesizer channels.
// - Sync enable resets to one, so resync is active after reset.
// - Powerdown bit 0 resets to zero, so synthesizer starts and calibrates.
// - Setting powerdown disables the synthesizer and holds calibration reset.
// - Clearing powerdown re-enables and restarts calibration from scratch.
`timescale 1ns/1ns
`default_nettype none
module pll_post_divider_power_ctrl #(
    parameter int CalCycles = pll_ctrl_pkg::CAL_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic nvmLoad,
    input wire logic [7:0] nvmData,
    input wire logic syncPin,
    input wire logic vcoTick,
    output logic [3:0] postDivRatio,
    output logic postDivTick,
    output logic synthEnable,
    output logic calReset,
    output logic calBusy,
    output logic calDone,
    output logic channelResync
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------

    // The sequencer needs at least one cycle to count.
    if (CalCycles < 1) begin
        $error("CalCycles must be one or more");
    end

    // The select field must be exactly as wide as the stored code, and
    // it must stay clear of the reserved bits, which read as zero.
    localparam int DivWidth = pll_ctrl_pkg::POSTDIV_MSB
                              - pll_ctrl_pkg::POSTDIV_LSB + 1;
    if (DivWidth != 3) begin
        $error("post-divider field must be three bits wide");
    end
    if (pll_ctrl_pkg::POSTDIV_MSB > 4) begin
        $error("post-divider field overlaps the reserved bits");
    end

    // The two single-bit fields sit below the select field and apart,
    // otherwise one write would land in two places at once.
    if (pll_ctrl_pkg::SYNC_EN_BIT >= pll_ctrl_pkg::POSTDIV_LSB ||
        pll_ctrl_pkg::PDN_BIT >= pll_ctrl_pkg::POSTDIV_LSB ||
        pll_ctrl_pkg::SYNC_EN_BIT == pll_ctrl_pkg::PDN_BIT) begin
        $error("single-bit fields overlap");
    end

    // Control and status must decode apart, or a read would be ambiguous.
    if (pll_ctrl_pkg::CTRL_ZERO_ADDR == pll_ctrl_pkg::STATUS_ADDR) begin
        $error("control and status share one address");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Maps the three-bit select code onto its division ratio.
    // Codes below two share the smallest ratio of two.
    function automatic logic [3:0] ratioOf(input logic [2:0] code);
        logic [3:0] ratio;
        if (code < 3'h2) begin
            ratio = 4'h2;
        end else begin
            ratio = {1'b0, code} + 4'h1;
        end
        return ratio;
    endfunction

    // Packs the stored fields into the visible register image.
    // Reserved bits start at zero and nothing ever sets them.
    function automatic logic [7:0] packCtrl(
        input logic [2:0] div,
        input logic syncEn,
        input logic pdn
    );
        logic [7:0] image;
        image = 8'h00;
        image[pll_ctrl_pkg::POSTDIV_MSB:pll_ctrl_pkg::POSTDIV_LSB] = div;
        image[pll_ctrl_pkg::SYNC_EN_BIT] = syncEn;
        image[pll_ctrl_pkg::PDN_BIT] = pdn;
        return image;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Stored fields, decode strobes and the link to the sequencer.
    logic [2:0] postDivSel;
    logic syncEnable;
    logic synthPowerdown;
    logic ctrlWrite;
    logic [7:0] loadImage;
    logic loadAny;
    logic syncEvent;
    logic [3:0] divCount;
    logic [7:0] next_regRdData;
    cal_if cal ();

    // ------------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------------

    // A software write is preferred over a nonvolatile preload in the
    // same cycle, because the preload is only a power-up convenience.
    // The preload runs on this clock, so it needs no synchroniser; it
    // carries the whole byte image, reserved bits included, and those
    // bits are dropped exactly as they are for a software write.
    assign ctrlWrite = regWr && (regAddr == pll_ctrl_pkg::CTRL_ZERO_ADDR);
    assign loadAny = ctrlWrite || nvmLoad;
    assign loadImage = ctrlWrite ? regWrData : nvmData;

    // Post-divider select field.
    always_ff @(posedge clk) begin
        if (reset) begin
            postDivSel <= pll_ctrl_pkg::POSTDIV_RESET;
        end else if (loadAny) begin
            postDivSel <= loadImage[pll_ctrl_pkg::POSTDIV_MSB:
                                    pll_ctrl_pkg::POSTDIV_LSB];
        end
    end

    // Sync enable bit, set by default so resync works out of reset.
    // Clearing it makes the block ignore sync events from the pin.
    always_ff @(posedge clk) begin
        if (reset) begin
            syncEnable <= pll_ctrl_pkg::SYNC_EN_RESET;
        end else if (loadAny) begin
            syncEnable <= loadImage[pll_ctrl_pkg::SYNC_EN_BIT];
        end
    end

    // Powerdown bit; clear after reset so the synthesizer comes up.
    // Setting it stops the synthesizer and holds calibration; clearing
    // it lets the sequencer start over at once.
    always_ff @(posedge clk) begin
        if (reset) begin
            synthPowerdown <= pll_ctrl_pkg::PDN_RESET;
        end else if (loadAny) begin
            synthPowerdown <= loadImage[pll_ctrl_pkg::PDN_BIT];
        end
    end

    // Bits 7:5 of the written byte have no storage, so they vanish.

    // ------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------

    // Read data appear only in the cycle after the strobe; an unmapped
    // address and an idle cycle both return zero.
    // Returning zero outside the read cycle lets several slaves share
    // one read-data bus through a plain OR, with no multiplexer.
    // The status byte shows calibration done in bit 0, busy in bit 1
    // and synthesizer enabled in bit 2; its other bits read as zero.
    always_comb begin
        next_regRdData = 8'h00;
        if (regRd) begin
            case (regAddr)
                pll_ctrl_pkg::CTRL_ZERO_ADDR: begin
                    next_regRdData = packCtrl(postDivSel, syncEnable,
                                              synthPowerdown);
                end
                pll_ctrl_pkg::STATUS_ADDR: begin
                    next_regRdData[pll_ctrl_pkg::STAT_DONE_BIT] = cal.done;
                    next_regRdData[pll_ctrl_pkg::STAT_BUSY_BIT] = cal.busy;
                    next_regRdData[pll_ctrl_pkg::STAT_ENABLE_BIT] =
                        ~synthPowerdown;
                end
                default: begin
                    next_regRdData = 8'h00;
                end
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------
    // Synthesizer enable and calibration
    // ------------------------------------------------------------------

    // The sequencer is enabled exactly while powerdown is clear; when
    // powerdown drops it restarts from the held state with no help from
    // software.
    // The calibration length is a parameter so that a bench can run a
    // short sequence; the default covers the full settling time.
    assign cal.enable = ~synthPowerdown;

    calibration_sequencer #(
        .CalCycles(CalCycles)
    ) u_cal (
        .clk(clk),
        .reset(reset),
        .cal(cal)
    );

    // Status outputs are registered so the pins never glitch.
    // The copies trail the internal state by one cycle; the status
    // register reads the sequencer directly, but its read data are registered too, so they trail by the same cycle as the pins.
    // During reset the synthesizer is shown disabled and calibration
    // held, and both come free on the first edge after release.
    always_ff @(posedge clk) begin
        if (reset) begin
            synthEnable <= 1'b0;
            calReset <= 1'b1;
            calBusy <= 1'b0;
            calDone <= 1'b0;
        end else begin
            synthEnable <= ~synthPowerdown;
            calReset <= synthPowerdown;
            calBusy <= cal.busy;
            calDone <= cal.done;
        end
    end

    // ------------------------------------------------------------------
    // Sync event handling
    // ------------------------------------------------------------------
    sync_event_detect u_sync (
        .clk(clk),
        .reset(reset),
        .syncPin(syncPin),
        .syncEvent(syncEvent)
    );

    // A sync edge is forwarded to the channels only when enabled. A
    // powered-down synthesizer has no clock to realign, so it is held.
    // From pin to pulse takes three edges: two synchroniser stages and
    // this flop. A pin pulse shorter than one clock period may be
    // missed, so sync sources must hold the level for two cycles.
    always_ff @(posedge clk) begin
        if (reset) begin
            channelResync <= 1'b0;
        end else begin
            channelResync <= syncEvent && syncEnable
                             && !synthPowerdown;
        end
    end

    // ------------------------------------------------------------------
    // Post divider
    // ------------------------------------------------------------------

    // Registered ratio for the analog divider and for observation.
    always_ff @(posedge clk) begin
        if (reset) begin
            postDivRatio <= ratioOf(pll_ctrl_pkg::POSTDIV_RESET);
        end else begin
            postDivRatio <= ratioOf(postDivSel);
        end
    end

    // Counts synthesizer ticks and emits one tick per ratio. A resync
    // restarts the count so all channels share one phase.
    // A ratio change takes effect at once against the live count, limiting a glitch
    // to one short or long period at most.
    // Powerdown and resync both clear the count and the tick, so the
    // first tick after either comes a full ratio of input ticks later.
    always_ff @(posedge clk) begin
        if (reset) begin
            divCount <= 4'h0;
            postDivTick <= 1'b0;
        end else if (synthPowerdown || channelResync) begin
            divCount <= 4'h0;
            postDivTick <= 1'b0;
        end else if (vcoTick) begin
            if (divCount >= postDivRatio - 4'h1) begin
                divCount <= 4'h0;
                postDivTick <= 1'b1;
            end else begin
                divCount <= divCount + 4'h1;
                postDivTick <= 1'b0;
            end
        end else begin
            postDivTick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: pll_post_divider_power_ctrl_sva.sv
// Concurrent checks on the control register block ports.
`timescale 1ns/1ns
`default_nettype none
module pll_post_divider_power_ctrl_sva #(
    parameter int CalCycles = pll_ctrl_pkg::CAL_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic vcoTick,
    input wire logic [3:0] postDivRatio,
    input wire logic postDivTick,
    input wire logic synthEnable,
    input wire logic calReset,
    input wire logic calBusy,
    input wire logic calDone,
    input wire logic channelResync
);
    // Margin covers the held-to-run step and the registered done flag.
    localparam int CalMax = CalCycles + 4;
    logic ctlHit;
    assign ctlHit = regAddr == pll_ctrl_pkg::CTRL_ZERO_ADDR;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_reset_state: assert property (
        $fell(reset) |-> postDivRatio == 4'h8 && calReset && !synthEnable
    ) else $error("reset state wrong");
    a_ratio_range: assert property (
        postDivRatio >= 4'h2 && postDivRatio <= 4'h8
    ) else $error("ratio out of range");
    a_tick_cause: assert property (
        postDivTick |-> $past(vcoTick)
    ) else $error("divider tick without input tick");
    a_rsvd_zero: assert property (
        regRd && ctlHit |=> regRdData[7:5] == 3'h0
    ) else $error("reserved bits read nonzero");
    a_rd_idle: assert property (
        !regRd |=> regRdData == 8'h00
    ) else $error("read data outside read cycle");
    // The register bit lands one edge after the write and the pins
    // follow one edge later still.
    a_pdn_set: assert property (
        regWr && ctlHit && regWrData[pll_ctrl_pkg::PDN_BIT]
        |-> ##2 (!synthEnable && calReset)
    ) else $error("powerdown did not disable");
    a_pdn_clear: assert property (
        regWr && ctlHit && !regWrData[pll_ctrl_pkg::PDN_BIT]
        |-> ##2 (synthEnable && !calReset)
    ) else $error("powerup did not enable");
    a_held_idle: assert property (
        calReset ##1 calReset |-> !calBusy && !calDone
    ) else $error("calibration active while held");
    a_cal_restart: assert property (
        $fell(calReset) |-> ##[1:4] calBusy
    ) else $error("calibration did not restart");
    // A powerdown may legally cut a run short.
    a_busy_hold: assert property (
        $rose(calBusy) |-> (calBusy || calReset)[*3]
    ) else $error("calibration run too short");
    a_cal_finish: assert property (
        $rose(calBusy) |-> ##[1:CalMax] (calDone || calReset)
    ) else $error("calibration did not finish");
    a_resync_pulse: assert property (
        channelResync |=> !channelResync
    ) else $error("resync pulse too long");
endmodule

bind pll_post_divider_power_ctrl pll_post_divider_power_ctrl_sva #(
    .CalCycles(CalCycles)
) sva_u (
    .clk(clk),
    .reset(reset),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .vcoTick(vcoTick),
    .postDivRatio(postDivRatio),
    .postDivTick(postDivTick),
    .synthEnable(synthEnable),
    .calReset(calReset),
    .calBusy(calBusy),
    .calDone(calDone),
    .channelResync(channelResync)
);
`default_nettype wire

// file: sync_event_detect.sv
// Synchroniser and rising-edge detector for the sync event pin.
`timescale 1ns/1ns
`default_nettype none
module sync_event_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic syncPin,
    output logic syncEvent
);
    logic stageOne;
    logic stageTwo;
    logic stageLast;

    // Two flops tame the asynchronous pin before anything looks at it.
    always_ff @(posedge clk) begin
        if (reset) begin
            stageOne <= 1'b0;
            stageTwo <= 1'b0;
        end else begin
            stageOne <= syncPin;
            stageTwo <= stageOne;
        end
    end

    // Edge memory reads only the second stage.
    always_ff @(posedge clk) begin
        if (reset) begin
            stageLast <= 1'b0;
        end else begin
            stageLast <= stageTwo;
        end
    end

    // One pulse per rising edge of the pin.
    assign syncEvent = stageTwo & ~stageLast;
endmodule
`default_nettype wire

// file: tb_pll_post_divider_power_ctrl.sv
// Self-checking bench for the synthesizer control register block.
`timescale 1ns/1ns
`default_nettype none
module tb_pll_post_divider_power_ctrl;
    localparam logic [7:0] Ctl = pll_ctrl_pkg::CTRL_ZERO_ADDR;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic nvmLoad = 1'b0;
    logic [7:0] nvmData = 8'h00;
    logic syncPin = 1'b0;
    logic vcoTick = 1'b0;
    logic [3:0] postDivRatio;
    logic postDivTick, synthEnable, calReset, calBusy, calDone;
    logic channelResync;
    logic [7:0] expQ[$];
    logic rdTaken = 1'b0;
    logic [31:0] rnd;
    int errors = 0;
    int comparisons = 0;
    int seed = 37;

    // A short calibration keeps the run brief.
    pll_post_divider_power_ctrl #(.CalCycles(4)) dut_u (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .nvmLoad(nvmLoad), .nvmData(nvmData),
        .syncPin(syncPin), .vcoTick(vcoTick),
        .postDivRatio(postDivRatio), .postDivTick(postDivTick),
        .synthEnable(synthEnable), .calReset(calReset),
        .calBusy(calBusy), .calDone(calDone),
        .channelResync(channelResync)
    );

    initial forever #25 clk = ~clk;

    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Read data stand one cycle only, so they are taken mid-cycle.
    always @(posedge clk) rdTaken <= regRd;
    always @(negedge clk) begin
        if (rdTaken) chk(regRdData, expQ.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    task automatic waitDone();
        int n;
        n = 0;
        while (calDone !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                errors++;
                stop_test();
            end
        end
    endtask

    // Counts resync pulses that follow one rising sync edge.
    task automatic syncCount(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        syncPin <= 1'b1;
        repeat (10) begin
            @(negedge clk);
            if (channelResync === 1'b1) n++;
        end
        @(posedge clk);
        syncPin <= 1'b0;
        chk(n, e);
    endtask

    // The ratio is registered and applies at once, so the period is measured after settling.
    task automatic divCheck(input logic [3:0] r);
        int n;
        n = 0;
        vcoTick <= 1'b1;
        repeat (20) @(negedge clk);
        chk({4'h0, postDivRatio}, {4'h0, r});
        while (postDivTick !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (postDivTick !== 1'b1 && n < 20);
        chk(8'(n), {4'h0, r});
        @(posedge clk);
        vcoTick <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(negedge clk);
        chk({6'h0, synthEnable, calReset}, 8'h02);
        rd(Ctl, 8'h1e);
        waitDone();
        wr(Ctl, 8'hff);
        // Powerdown reaches the pins one cycle after the register.
        repeat (2) @(negedge clk);
        chk({6'h0, synthEnable, calReset}, 8'h01);
        rd(Ctl, 8'h1f);
        @(negedge clk);
        chk({6'h0, calBusy, calDone}, 8'h00);
        wr(Ctl, 8'h1e);
        waitDone();
        rd(pll_ctrl_pkg::STATUS_ADDR, 8'h05);
        for (int c = 0; c < 8; c++) begin
            rnd = $random(seed);
            wr(Ctl, {rnd[7:5], c[2:0], 2'b10});
            rd(Ctl, {3'h0, c[2:0], 2'b10});
            divCheck((c < 2) ? 4'h2 : 4'(c + 1));
        end
        syncCount(8'h01);
        wr(Ctl, 8'h1c);
        syncCount(8'h00);
        wr(Ctl, 8'h1f);
        syncCount(8'h00);
        wr(Ctl, 8'h1e);
        waitDone();
        // Preload alone, then preload against a software write.
        @(posedge clk);
        nvmLoad <= 1'b1;
        nvmData <= 8'he9;
        @(posedge clk);
        nvmLoad <= 1'b0;
        rd(Ctl, 8'h09);
        @(posedge clk);
        nvmLoad <= 1'b1;
        nvmData <= 8'h00;
        regWr <= 1'b1;
        regAddr <= Ctl;
        regWrData <= 8'h0e;
        @(posedge clk);
        nvmLoad <= 1'b0;
        regWr <= 1'b0;
        rd(Ctl, 8'h0e);
        rd(8'h40, 8'h00);
        wr(8'h40, 8'hff);
        rd(Ctl, 8'h0e);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk({4'h0, postDivRatio}, 8'h08);
        chk({6'h0, synthEnable, calReset}, 8'h01);
        rd(Ctl, 8'h1e);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
